// [bench/serial_flash_pin_interface_sva.sv]
`timescale 1ns/1ns
// pin-level checks on the interface's status and lane outputs
module flash_pins_sva (
  // clock and reset
  input wire       clk_i,
  input wire       reset_i,
  // core side
  input wire [1:0] lane_mode_i,
  input wire       busy_i,
  input wire       rx_ready_i,
  input wire [7:0] rx_data_o,
  input wire       rx_valid_o,
  // pins and status
  input wire [3:0] data_lanes_oe_o,
  input wire       selected_o,
  input wire       frame_start_o,
  input wire       standby_o,
  input wire       protect_o,
  input wire       paused_o,
  input wire       overrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // mode held steady so registered outputs have caught up
  sequence s_quad;
    (lane_mode_i == 2'h2) [*3];
  endsequence
  sequence s_single;
    (lane_mode_i == 2'h0) [*3];
  endsequence
  a_idle_no_drive: assert property (!selected_o [*2] |->
    data_lanes_oe_o == 4'h0) else $error("lanes driven while idle");
  a_sel_no_standby: assert property (selected_o |-> !standby_o)
    else $error("standby while selected");
  a_busy_no_standby: assert property (busy_i [*2] |-> !standby_o)
    else $error("standby while busy");
  a_idle_standby: assert property ((!busy_i && !selected_o) [*3]
    |-> standby_o) else $error("no standby when idle");
  a_rx_holds: assert property (rx_valid_o && !rx_ready_i |=>
    rx_valid_o && $stable(rx_data_o)) else $error("rx byte dropped");
  a_start_pulse: assert property (frame_start_o |=>
    !frame_start_o ##0 selected_o) else $error("bad frame start");
  a_pause_release: assert property (paused_o [*2] |->
    data_lanes_oe_o == 4'h0) else $error("lanes driven in pause");
  a_quad_lanes: assert property (s_quad |-> !paused_o && !protect_o)
    else $error("pause or protect in quad");
  a_single_lane: assert property (s_single ##0 data_lanes_oe_o != 4'h0
    |-> data_lanes_oe_o == 4'h2) else $error("single uses wrong lane");
  a_overrun_keep: assert property (overrun_o && !frame_start_o
    |=> overrun_o) else $error("overrun lost");
endmodule // flash_pins_sva

// [bench/serial_flash_pin_interface_tb_top.sv]
`timescale 1ns/1ns
module serial_flash_pin_interface_tb_top;
  reg        clk_i = 1'b0, reset_i = 1'b1, tog = 1'b0;
  reg  [1:0] md = 2'h0;
  reg        dir = 1'b0, busy = 1'b0, rdy = 1'b1, tvld = 1'b0;
  reg  [7:0] tdat = 8'h00, b, got;
  reg  [3:0] s, msk;
  wire [3:0] lanes, d_o, d_oe, h_oe, h_v;
  wire [7:0] rdat;
  wire       sck, sel_n, rvld, trdy, selected, fst, fen, stby, prot, pau, ovr;
  integer    bad_count = 0, checks_done = 0, seed = 17, i, k, m, w;
  integer    nst = 0, nen = 0;
  reg  [7:0] rq[$], tq[$];
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) tog <= ~tog;
  // released lanes: pull-ups on 2 and 3, a moving pattern on 0 and 1
  assign lanes = (d_oe & d_o) | (~d_oe & h_oe & h_v)
               | (~d_oe & ~h_oe & {2'b11, tog, ~tog});
  serial_flash_pin_interface dut (.clk_i(clk_i), .reset_i(reset_i),
    .sck_i(sck), .select_n_i(sel_n), .data_lanes_i(lanes),
    .data_lanes_o(d_o), .data_lanes_oe_o(d_oe), .lane_mode_i(md),
    .out_dir_i(dir), .busy_i(busy), .rx_data_o(rdat), .rx_valid_o(rvld),
    .rx_ready_i(rdy), .tx_data_i(tdat), .tx_valid_i(tvld),
    .tx_ready_o(trdy), .selected_o(selected), .frame_start_o(fst),
    .frame_end_o(fen), .standby_o(stby), .protect_o(prot),
    .paused_o(pau), .overrun_o(ovr));
  spi_host_model u_host (.sck_o(sck), .select_n_o(sel_n),
    .lane_oe_o(h_oe), .lane_val_o(h_v), .lanes_i(lanes));
  task cmp(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task cmp_flag(input g, input e);
    cmp({7'h00, g}, {7'h00, e});
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // core inputs change just after a clock edge
  task core(input [1:0] a, input d, input bz);
    begin
      @(posedge clk_i);
      #1 md = a;
      dir = d;
      busy = bz;
    end
  endtask
  // one byte msb first over w lanes
  task send(input [7:0] v, input integer w);
    for (k = 8 - w; k >= 0; k = k - w)
      u_host.unit(4'((1 << w) - 1), 4'(v >> k), s);
  endtask
  // model of the received stream; each accepted byte must be expected
  always @(posedge clk_i) begin
    nst <= nst + (fst === 1'b1);
    nen <= nen + (fen === 1'b1);
    if (rvld === 1'b1 && rdy) begin
      if (rq.size() == 0) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t unexpected byte", $time);
      end else cmp(rdat, rq.pop_front());
    end
    if (trdy === 1'b1 && tvld) tq.push_back(tdat);
  end
  initial begin
    #1000000 bad_count = bad_count + 1;
    $display("[FAIL] %0t timeout", $time);
    wrap_up;
  end
  initial begin
    #31 reset_i = 1'b0;
    repeat (5) @(posedge clk_i);
    // receive: single, dual then quad, two bytes back to back
    for (m = 0; m < 3; m = m + 1) begin
      core(2'(m), 1'b0, 1'b0);
      w = 1 << m;
      u_host.frame(1);
      cmp_flag(selected, 1'b1);
      for (i = 0; i < 2; i = i + 1) begin
        b = $random(seed);
        rq.push_back(b);
        send(b, w);
      end
      u_host.frame(0);
    end
    // clocking while deselected, then a frame cut after half a byte
    core(2'h0, 1'b0, 1'b0);
    for (i = 0; i < 8; i = i + 1)
      u_host.unit(4'h1, 4'($random(seed)), s);
    u_host.frame(1);
    for (i = 0; i < 4; i = i + 1) u_host.unit(4'h1, 4'($random(seed)), s);
    u_host.frame(0);
    // pause in mid-byte, garbage while paused, busy across deselect
    b = $random(seed);
    rq.push_back(b);
    u_host.frame(1);
    for (k = 7; k > 3; k = k - 1) u_host.unit(4'h1, 4'(b >> k), s);
    u_host.drive(4'h9, 4'h0);
    cmp_flag(pau, 1'b1);
    cmp({4'h0, d_oe}, 8'h00);
    for (i = 0; i < 4; i = i + 1)
      u_host.unit(4'h9, 4'($random(seed)) & 4'h7, s);
    core(2'h0, 1'b0, 1'b1);
    u_host.drive(4'h1, 4'h0);
    for (k = 3; k >= 0; k = k - 1) u_host.unit(4'h1, 4'(b >> k), s);
    u_host.frame(0);
    cmp_flag(stby, 1'b0);
    core(2'h0, 1'b0, 1'b0);
    u_host.drive(4'h0, 4'h0);
    cmp_flag(stby, 1'b1);
    // transmit in single, dual and quad lane modes
    for (m = 0; m < 3; m = m + 1) begin
      w = 1 << m;
      msk = 4'((1 << w) - 1);
      core(2'(m), 1'b1, 1'b0);
      tdat = $random(seed);
      tvld = 1'b1;
      u_host.frame(1);
      got = 8'h00;
      for (i = 0; i <= 8 / w; i = i + 1) begin
        u_host.unit(4'h0, 4'($random(seed)), s);
        if (i > 0) begin
          got = (got << w) | (m == 0 ? {7'h00, s[1]} : {4'h0, s & msk});
          cmp({4'h0, d_oe}, m == 0 ? 8'h02 : {4'h0, msk});
        end
      end
      core(2'(m), 1'b1, 1'b0);
      tvld = 1'b0;
      cmp(got, tq[0]);
      u_host.frame(0);
      tq.delete();
    end
    // write-protect pin: low asserts, released reads high, quad ignores
    core(2'h0, 1'b0, 1'b0);
    u_host.drive(4'h4, 4'h0);
    cmp_flag(prot, 1'b1);
    u_host.drive(4'h0, 4'h0);
    cmp_flag(prot, 1'b0);
    core(2'h2, 1'b0, 1'b0);
    u_host.drive(4'h4, 4'h0);
    cmp_flag(prot, 1'b0);
    // fill the fifo until it refuses, then drain it
    core(2'h0, 1'b0, 1'b0);
    rdy = 1'b0;
    u_host.frame(1);
    for (i = 0; i < 10; i = i + 1) begin
      b = $random(seed);
      rq.push_back(b);
      send(b, 1);
    end
    u_host.frame(0);
    cmp_flag(ovr, 1'b1);
    @(posedge clk_i);
    #1 rdy = 1'b1;
    repeat (30) @(posedge clk_i);
    #1 rq.delete();
    u_host.frame(1);
    cmp_flag(ovr, 1'b0);
    u_host.frame(0);
    cmp(8'(nst), 8'(u_host.starts));
    cmp(8'(nen), 8'(u_host.starts));
    wrap_up;
  end
endmodule // serial_flash_pin_interface_tb_top
bind serial_flash_pin_interface flash_pins_sva u_sva (.clk_i, .reset_i,
  .lane_mode_i, .busy_i, .rx_ready_i, .rx_data_o, .rx_valid_o,
  .data_lanes_oe_o, .selected_o, .frame_start_o, .standby_o,
  .protect_o, .paused_o, .overrun_o);

// [bench/spi_host_model.sv]
`timescale 1ns/1ns
// mode 0 host; the clock rests low outside frames
module spi_host_model (
  // pins towards the device
  output reg        sck_o,
  output reg        select_n_o,
  output reg  [3:0] lane_oe_o,
  output reg  [3:0] lane_val_o,
  // resolved lanes
  input  wire [3:0] lanes_i
);
  integer starts = 0;
  // idle: deselected, clock low, lanes released
  initial begin
    sck_o = 1'b0;
    select_n_o = 1'b1;
    lane_oe_o = 4'h0;
    lane_val_o = 4'h0;
  end
  // select edges only while the clock is low
  task frame(input bit on);
    begin
      #80 select_n_o = !on;
      starts = starts + on;
      #160;
    end
  endtask
  // one clock period; sampling late in high covers the sync delay
  task unit(input [3:0] oe, input [3:0] v, output [3:0] s);
    begin
      lane_oe_o = oe;
      lane_val_o = v;
      #80 sck_o = 1'b1;
      #60 s = lanes_i;
      #20 sck_o = 1'b0;
    end
  endtask
  // static pin levels, clock held low
  task drive(input [3:0] oe, input [3:0] v);
    begin
      lane_oe_o = oe;
      lane_val_o = v;
      #200;
    end
  endtask
endmodule // spi_host_model

// [hdl/byte_fifo.v]
`timescale 1ns/1ns
// small synchronous fifo with valid and ready on both sides
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             reset_i,
  // fill side
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            push;
  wire            pop;

  // extra pointer bit tells full from empty
  assign out_valid_o = (wr_reg != rd_reg);
  assign in_ready_o  = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) ||
                       (wr_reg[AW] == rd_reg[AW]);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_reg[AW-1:0]];

  // storage has no reset; pointers guard it
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // pointer update
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule // byte_fifo

// [hdl/flash_pins_map.vh]
`ifndef FLASH_PINS_MAP_VH
`define FLASH_PINS_MAP_VH
// lane widths and modes
`define LANE_MODE_W      2
`define LANE_MODE_SINGLE 2'h0
`define LANE_MODE_DUAL   2'h1
`define LANE_MODE_QUAD   2'h2
`define LANE_W           4
`define BYTE_W           8
// bit counter for one byte
`define BIT_CNT_W        3
`define BIT_CNT_ZERO     3'h0
`define BIT_CNT_LAST     3'h7
// lane indices
`define LANE_SI          0
`define LANE_SO          1
`define LANE_WP          2
`define LANE_PAUSE       3
// fifo
`define FIFO_WIDTH       8
`define FIFO_DEPTH       8
`define FIFO_AW          3
`define SYNC_RESET       3'h0
`define SYNC_ONES        3'h7
`endif

// [hdl/pin_sync.v]
`timescale 1ns/1ns
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync #(
  // reset level of every stage: the pin's idle level, so no false edge
  parameter [0:0] INIT = 1'b0
) (
  // clock and reset
  input  wire clk_i,
  input  wire reset_i,
  // pin side
  input  wire pin_i,
  // synchronised level
  output reg  level_o
);
  `include "flash_pins_map.vh"
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // stage one is read only by stage two
  always @(posedge clk_i) begin
    if (reset_i) begin
      s1_reg  <= INIT;
      s2_reg  <= INIT;
      s3_reg  <= INIT;
      level_o <= INIT;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule // pin_sync

// [hdl/serial_flash_pin_interface.v]
`timescale 1ns/1ns
// Function
// - select low enables the device; select high deselects into standby
// - standby waits after deselect until the internal busy cycle ends
// - lane input bits are sampled on each rising serial clock edge
// - output bits change on each falling serial clock edge
// - deselected, output lane is released and input lane ignored
// - no byte is captured from the input pin while deselected
// - dual read drives lanes 0 and 1, two bits per falling edge
// - quad read drives lanes 0 to 3, four bits per falling edge
// - quad program samples lanes 0 to 3 on rising edges
// - write-protect pin is pulled up, unconnected reads as not asserted
// - pause freezes clock and input and releases the outputs
// - pause never disturbs a running internal program or erase cycle
// - only clock modes 0 and 3: rising samples, falling drives
module serial_flash_pin_interface (
  // system clock and reset
  input  wire       clk_i,
  input  wire       reset_i,
  // serial link pins
  input  wire       sck_i,
  input  wire       select_n_i,
  input  wire [3:0] data_lanes_i,
  output reg  [3:0] data_lanes_o,
  output reg  [3:0] data_lanes_oe_o,
  // core side: lane mode chosen by the command decoder
  input  wire [1:0] lane_mode_i,
  input  wire       out_dir_i,
  input  wire       busy_i,
  // core side: received bytes
  output reg  [7:0] rx_data_o,
  output reg        rx_valid_o,
  input  wire       rx_ready_i,
  // core side: bytes to send
  input  wire [7:0] tx_data_i,
  input  wire       tx_valid_i,
  output reg        tx_ready_o,
  // status
  output reg        selected_o,
  output reg        frame_start_o,
  output reg        frame_end_o,
  output reg        standby_o,
  output reg        protect_o,
  output reg        paused_o,
  output reg        overrun_o
);
  `include "flash_pins_map.vh"

  wire       sck_s;
  wire       sel_n_s;
  wire [3:0] lane_s;
  reg        sck_d_reg;
  reg        sel_n_d_reg;
  reg  [7:0] rx_sh_reg;
  reg  [7:0] rx_sh_next;
  reg  [2:0] rx_cnt_reg;
  reg  [2:0] rx_cnt_next;
  reg  [7:0] tx_sh_reg;
  reg  [2:0] tx_cnt_reg;
  reg        tx_loaded_reg;
  reg        byte_done;
  wire       fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  wire       fifo_out_ready;
  wire       sck_rise;
  wire       sck_fall;
  wire       active;
  wire       lanes_quad;
  wire [3:0] oe_want;

  // width of a lane step for the current mode
  function [2:0] step;
    input [1:0] mode;
    begin
      case (mode)
        `LANE_MODE_DUAL: step = 3'h2;
        `LANE_MODE_QUAD: step = 3'h4;
        default:         step = 3'h1;
      endcase
    end
  endfunction

  // every pin crosses in through four flops; reset levels match idle pins
  // so that no frame edge or pause is seen right after reset
  pin_sync #(
    .INIT (1'b0)
  ) u_sync_sck (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (sck_i),
    .level_o (sck_s)
  );
  pin_sync #(
    .INIT (1'b1)
  ) u_sync_sel (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (select_n_i),
    .level_o (sel_n_s)
  );
  genvar g;
  generate
    for (g = 0; g < `LANE_W; g = g + 1) begin : g_lane
      pin_sync #(
        .INIT (1'b1)
      ) u_sync_lane (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (data_lanes_i[g]),
        .level_o (lane_s[g])
      );
    end
  endgenerate

  // quad modes claim write-protect and pause as data lanes
  assign lanes_quad = (lane_mode_i == `LANE_MODE_QUAD);
  // pause is a low level on lane 3 while it is no data lane
  wire pause_now = !lanes_quad && !lane_s[`LANE_PAUSE] && !sel_n_s;
  // selected and not paused; clock edges during pause are dropped
  assign active   = !sel_n_s && !pause_now;
  assign sck_rise = active && sck_s && !sck_d_reg;
  assign sck_fall = active && !sck_s && sck_d_reg;

  // edge history of clock and select
  always @(posedge clk_i) begin
    if (reset_i) begin
      sck_d_reg   <= 1'b0;
      sel_n_d_reg <= 1'b1;
    end else begin
      sck_d_reg   <= sck_s;
      sel_n_d_reg <= sel_n_s;
    end
  end

  // frame markers on select edges
  always @(posedge clk_i) begin
    if (reset_i) begin
      frame_start_o <= 1'b0;
      frame_end_o   <= 1'b0;
      selected_o    <= 1'b0;
    end else begin
      frame_start_o <= sel_n_d_reg && !sel_n_s;
      frame_end_o   <= !sel_n_d_reg && sel_n_s;
      selected_o    <= !sel_n_s;
    end
  end

  // standby only when deselected and no internal cycle is running;
  // pause is not consulted here, so busy work carries on through it
  always @(posedge clk_i) begin
    if (reset_i) begin
      standby_o <= 1'b1;
      paused_o  <= 1'b0;
      protect_o <= 1'b0;
    end else begin
      standby_o <= sel_n_s && !busy_i;
      paused_o  <= pause_now;
      // pulled high: a floating pin gives no protection
      protect_o <= !lanes_quad && !lane_s[`LANE_WP];
    end
  end

  // receive shifter: collects bits msb first, lane 3 highest
  always @* begin
    rx_sh_next  = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    byte_done   = 1'b0;
    if (sck_rise && !out_dir_i) begin
      case (lane_mode_i)
        `LANE_MODE_QUAD: rx_sh_next = {rx_sh_reg[3:0], lane_s};
        `LANE_MODE_DUAL: rx_sh_next = {rx_sh_reg[5:0], lane_s[1:0]};
        default:         rx_sh_next = {rx_sh_reg[6:0], lane_s[`LANE_SI]};
      endcase
      rx_cnt_next = rx_cnt_reg + step(lane_mode_i);
      byte_done   = (rx_cnt_next == `BIT_CNT_ZERO);
    end
  end

  // deselect drops a partial byte so nothing leaks between frames
  always @(posedge clk_i) begin
    if (reset_i || sel_n_s) begin
      rx_sh_reg  <= 8'h00;
      rx_cnt_reg <= `BIT_CNT_ZERO;
    end else begin
      rx_sh_reg  <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  // overrun flags a byte lost to a full fifo; the host clock cannot wait
  always @(posedge clk_i) begin
    if (reset_i) begin
      overrun_o <= 1'b0;
    end else if (byte_done && !fifo_in_ready) begin
      overrun_o <= 1'b1;
    end else if (frame_start_o) begin
      overrun_o <= 1'b0;
    end
  end

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   (rx_sh_next),
    .in_valid_i  (byte_done),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready)
  );

  // registered skid: take a fifo word whenever the output slot is free
  assign fifo_out_ready = !rx_valid_o || rx_ready_i;
  always @(posedge clk_i) begin
    if (reset_i) begin
      rx_data_o  <= 8'h00;
      rx_valid_o <= 1'b0;
    end else if (fifo_out_ready) begin
      rx_data_o  <= fifo_out_data;
      rx_valid_o <= fifo_out_valid;
    end
  end

  // transmit shifter: new bits appear on each falling edge
  always @(posedge clk_i) begin
    if (reset_i || sel_n_s) begin
      tx_sh_reg     <= 8'h00;
      tx_cnt_reg    <= `BIT_CNT_ZERO;
      tx_loaded_reg <= 1'b0;
      tx_ready_o    <= 1'b0;
    end else begin
      tx_ready_o <= !tx_loaded_reg && !tx_ready_o;
      if (tx_ready_o && tx_valid_i) begin
        tx_sh_reg     <= tx_data_i;
        tx_loaded_reg <= 1'b1;
        tx_cnt_reg    <= `BIT_CNT_ZERO;
      end else if (sck_fall && out_dir_i && tx_loaded_reg) begin
        // the pins take the top bits at this edge, the next ones move up
        tx_sh_reg  <= tx_sh_reg << step(lane_mode_i);
        tx_cnt_reg <= tx_cnt_reg + step(lane_mode_i);
        if (tx_cnt_reg + step(lane_mode_i) == `BIT_CNT_ZERO) begin
          tx_loaded_reg <= 1'b0;
        end
      end
    end
  end

  // lanes driven per mode; released when deselected or paused; kept on
  // after the last bit so that it stands until the next falling edge
  assign oe_want = (!active || !out_dir_i) ? 4'h0 :
                   (lane_mode_i == `LANE_MODE_QUAD) ? 4'hf :
                   (lane_mode_i == `LANE_MODE_DUAL) ? 4'h3 :
                   4'h2;

  // pins updated on falling edges, enables follow select at once
  always @(posedge clk_i) begin
    if (reset_i) begin
      data_lanes_o    <= 4'h0;
      data_lanes_oe_o <= 4'h0;
    end else begin
      data_lanes_oe_o <= oe_want;
      if (sck_fall || !active) begin
        case (lane_mode_i)
          `LANE_MODE_QUAD: data_lanes_o <= tx_sh_reg[7:4];
          `LANE_MODE_DUAL: data_lanes_o <= {2'b00, tx_sh_reg[7:6]};
          default:         data_lanes_o <= {2'b00, tx_sh_reg[7], 1'b0};
        endcase
      end
    end
  end
endmodule // serial_flash_pin_interface
